// File: iocec_pkg.sv
// Shared constants for the I/O channel error check block
package iocec_pkg;

	// ****************************************
	// Command word layout (bit 0 is the MSB of 64)
	// ****************************************
	localparam int CCW_W          = 64;
	localparam int CMD_HI         = 63;   // Command byte, word bits 0-7
	localparam int CMD_LO         = 56;
	localparam int CMD_LOW4_HI    = 59;   // Word bits 4-7
	localparam int CMD_LOW4_LO    = 56;
	localparam int FLAG_PCI_POS   = 29;   // Word bit 34
	localparam int RSV_HI         = 26;   // Word bits 37-39
	localparam int RSV_LO         = 24;
	localparam int CNT_HI         = 15;   // Word bits 48-63
	localparam int CNT_LO         = 0;
	localparam logic [3:0] CMD_TIC_LOW4 = 4'h8;

	// ****************************************
	// Status bits held in the channel status word
	// ****************************************
	localparam int ST_W        = 8;
	localparam int ST_PROG     = 0;   // Program check
	localparam int ST_PROT     = 1;   // Status bit 43
	localparam int ST_DATA     = 2;   // Status bit 44
	localparam int ST_IFC      = 3;   // Status bit 45
	localparam logic [ST_W-1:0] ST_RESET = 8'h00;

	// ****************************************
	// Buffer and selective reset timing
	// ****************************************
	localparam int BUF_DEPTH          = 2;
	localparam int SEL_RST_NS         = 250;
	localparam int CLK_NS             = 50;
	localparam int SEL_RST_CYC        = (SEL_RST_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [3:0] SEL_RST_CYC_W = 4'(SEL_RST_CYC);

endpackage

// File: iocec_buf.sv
// Two-entry valid/ready buffer for output data bytes
`timescale 1ns/1ps
`default_nettype none
module iocec_buf #(
	parameter int W = 10
) (
	input  wire logic         sys_clk,   // Clock
	input  wire logic         rst,       // Async reset
	input  wire logic [W-1:0] in_data,   // Fill data
	input  wire logic         in_valid,  // Fill valid
	output logic              in_ready,  // Room left
	output logic [W-1:0]      out_data,  // Drain data
	output logic              out_valid, // Drain valid
	input  wire logic         out_ready  // Drain ready
);
	import iocec_pkg::*;

	logic [W-1:0] mem_reg [BUF_DEPTH];
	logic         wp_reg;
	logic         rp_reg;
	logic [1:0]   cnt_reg;
	logic         push;
	logic         pop;

	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign in_ready  = (cnt_reg != 2'(BUF_DEPTH));
	assign out_valid = (cnt_reg != 2'h0);
	assign out_data  = mem_reg[rp_reg];

	always_ff @(posedge sys_clk)
	begin
		if (push)
			mem_reg[wp_reg] <= in_data;
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			wp_reg  <= 1'b0;
			rp_reg  <= 1'b0;
			cnt_reg <= 2'h0;
		end
		else
		begin
			if (push)
				wp_reg <= ~wp_reg;
			if (pop)
				rp_reg <= ~rp_reg;
			cnt_reg <= cnt_reg + 2'(push) - 2'(pop);
		end
	end
endmodule
`default_nettype wire

// File: iocec_top.sv
// Error detection and status bits of an I/O channel
`timescale 1ns/1ps
`default_nettype none
module iocec_top #(
	parameter int CNT_W = 16
) (
	input  wire logic                        sys_clk,        // 20 MHz clock
	input  wire logic                        rst,            // Async reset, high
	// Command word check
	input  wire logic                        ccw_valid,      // Fetched word strobe
	input  wire logic [iocec_pkg::CCW_W-1:0] ccw_word,       // Fetched command word
	input  wire logic                        ccw_first,      // First word of chain
	input  wire logic                        ccw_via_tic,    // Reached through transfer
	input  wire logic                        ccw_addr_exc,   // Address fault on word fetch
	input  wire logic                        ccw_prot_exc,   // Protection on word fetch
	input  wire logic                        ccw_chain,      // Word asks for chaining
	input  wire logic                        instr_invalid,  // Invalid instruction pulse
	// Storage data side
	input  wire logic                        in_wr_done,     // Input word written
	input  wire logic                        in_wr_prot,     // Protection on input write
	input  wire logic                        in_wr_addr,     // Address fault on input write
	input  wire logic                        in_wr_par,      // Storage parity on write
	input  wire logic                        in_bus_par_err, // Input bus parity error pulse
	input  wire logic                        out_byte_valid, // Output byte from storage
	output logic                             out_byte_ready, // Buffer can take a byte
	input  wire logic [7:0]                  out_byte,       // Output byte data
	input  wire logic                        out_byte_prot,  // Word had protection fault
	input  wire logic                        out_byte_addr,  // Word had address fault
	input  wire logic                        out_byte_par,   // Word had storage parity
	// Output bus to control units
	output logic [7:0]                       bus_out,        // Output data byte
	output logic                             bus_out_par,    // Output parity bit
	output logic                             bus_out_valid,  // Byte presented
	input  wire logic                        bus_out_take,   // Unit takes the byte
	// Interface byte checks, pins
	input  wire logic                        if_byte_stb,    // Address/status byte strobe
	input  wire logic [8:0]                  if_byte,        // Byte with parity bit 8
	input  wire logic                        if_is_cu_addr,  // Poll address from unit
	input  wire logic                        if_is_mux,      // Multiplexer channel mode
	input  wire logic                        sel_check,      // Selection answer strobe
	input  wire logic [7:0]                  sel_sent_addr,  // Address channel sent
	input  wire logic                        if_timing_err,  // Wrong timing pulse
	// Transfer control
	input  wire logic                        xfer_start,     // Load byte count
	input  wire logic [CNT_W-1:0]            xfer_count,     // Initial byte count
	input  wire logic                        unit_end,       // Unit ends transfer
	input  wire logic                        status_clear,   // Status stored/cleared
	output logic [iocec_pkg::ST_W-1:0]       status,         // Sticky error flags
	output logic                             chain_allow,    // Chaining may proceed
	output logic                             xfer_active,    // Transfer running
	output logic                             sel_reset       // Selective reset out
);
	import iocec_pkg::*;

	// ****************************************
	// Pin synchronisers for the interface strobes
	// ****************************************
	logic [2:0] s_ifstb;
	logic [2:0] s_selck;
	logic [2:0] s_tmerr;
	logic [8:0] ifb_q1, ifb_q2;
	logic [7:0] sent_q1, sent_q2;
	logic       cu_q1, cu_q2, mux_q1, mux_q2;

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			s_ifstb <= 3'h0;
			s_selck <= 3'h0;
			s_tmerr <= 3'h0;
		end
		else
		begin
			s_ifstb <= {s_ifstb[1:0], if_byte_stb};
			s_selck <= {s_selck[1:0], sel_check};
			s_tmerr <= {s_tmerr[1:0], if_timing_err};
		end
	end

	// Data held steady by the strobe, sampled twice before use
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			ifb_q1  <= 9'h000;
			ifb_q2  <= 9'h000;
			sent_q1 <= 8'h00;
			sent_q2 <= 8'h00;
			cu_q1   <= 1'b0;
			cu_q2   <= 1'b0;
			mux_q1  <= 1'b0;
			mux_q2  <= 1'b0;
		end
		else
		begin
			ifb_q1  <= if_byte;
			ifb_q2  <= ifb_q1;
			sent_q1 <= sel_sent_addr;
			sent_q2 <= sent_q1;
			cu_q1   <= if_is_cu_addr;
			cu_q2   <= cu_q1;
			mux_q1  <= if_is_mux;
			mux_q2  <= mux_q1;
		end
	end

	// Rising edge counts once stages two and three agree
	logic ifstb_lv, selck_lv, tmerr_lv;
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			ifstb_lv <= 1'b0;
			selck_lv <= 1'b0;
			tmerr_lv <= 1'b0;
		end
		else
		begin
			if (s_ifstb[1] == s_ifstb[2])
				ifstb_lv <= s_ifstb[2];
			if (s_selck[1] == s_selck[2])
				selck_lv <= s_selck[2];
			if (s_tmerr[1] == s_tmerr[2])
				tmerr_lv <= s_tmerr[2];
		end
	end
	logic ifstb_d, selck_d, tmerr_d;
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			ifstb_d <= 1'b0;
			selck_d <= 1'b0;
			tmerr_d <= 1'b0;
		end
		else
		begin
			ifstb_d <= ifstb_lv;
			selck_d <= selck_lv;
			tmerr_d <= tmerr_lv;
		end
	end
	logic if_ev, sel_ev, tm_ev;
	assign if_ev  = ifstb_lv && !ifstb_d;
	assign sel_ev = selck_lv && !selck_d;
	assign tm_ev  = tmerr_lv && !tmerr_d;

	// ****************************************
	// Command word checks
	// ****************************************
	logic is_tic;
	logic prog_ccw;
	logic wr_prot_ev;
	logic wr_addr_ev;
	// Fault levels only count with their write strobe
	assign wr_prot_ev = in_wr_done && in_wr_prot;
	assign wr_addr_ev = in_wr_done && in_wr_addr;
	assign is_tic = (ccw_word[CMD_LOW4_HI:CMD_LOW4_LO] == CMD_TIC_LOW4);
	assign prog_ccw = ccw_valid && (
		(ccw_word[CMD_LOW4_HI:CMD_LOW4_LO] == 4'h0) ||
		(!is_tic && ccw_word[CNT_HI:CNT_LO] == 16'h0000) ||
		(ccw_via_tic && is_tic) ||
		(ccw_first && (is_tic || ccw_word[FLAG_PCI_POS])) ||
		(ccw_word[RSV_HI:RSV_LO] != 3'h0) ||
		ccw_addr_exc);

	// ****************************************
	// Output path through the two-entry buffer
	// ****************************************
	logic [10:0] b_out;
	logic        b_valid;
	logic        b_ready;
	logic        stop_reg;
	logic        send;

	iocec_buf #(.W(11)) u_buf (
		.sys_clk   (sys_clk),
		.rst       (rst),
		.in_data   ({out_byte_par, out_byte_addr, out_byte_prot, out_byte}),
		.in_valid  (out_byte_valid && !stop_reg),
		.in_ready  (out_byte_ready),
		.out_data  (b_out),
		.out_valid (b_valid),
		.out_ready (b_ready)
	);

	// A faulty byte is only judged when it is really the next to go
	logic bad_prot, bad_addr, bad_par;
	assign bad_prot = b_valid && b_out[8] && xfer_active;
	assign bad_addr = b_valid && b_out[9] && xfer_active;
	assign bad_par  = b_valid && b_out[10] && xfer_active;
	assign b_ready  = !bus_out_valid || bus_out_take || stop_reg;
	assign send     = b_valid && b_ready && !stop_reg && !bad_prot && !bad_addr;

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			bus_out       <= 8'h00;
			bus_out_par   <= 1'b0;
			bus_out_valid <= 1'b0;
		end
		else if (send)
		begin
			bus_out       <= b_out[7:0];
			bus_out_par   <= b_out[10] ? ^b_out[7:0] : ~^b_out[7:0];
			bus_out_valid <= 1'b1;
		end
		else if (bus_out_take)
			bus_out_valid <= 1'b0;
	end

	// ****************************************
	// Byte count and transfer end
	// ****************************************
	logic [CNT_W-1:0] count_reg;
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			count_reg   <= '0;
			xfer_active <= 1'b0;
			stop_reg    <= 1'b0;
		end
		else if (xfer_start)
		begin
			count_reg   <= xfer_count;
			xfer_active <= 1'b1;
			stop_reg    <= 1'b0;
		end
		else
		begin
			if (send || (xfer_active && in_wr_done))
				count_reg <= count_reg - CNT_W'(1);
			// Data check does not end it; only count, unit or a protection or address fault does
			if (unit_end || ((send || in_wr_done) && count_reg == CNT_W'(1)))
				xfer_active <= 1'b0;
			// Stop after last good byte on protection or address fault
			if (bad_prot || bad_addr || wr_prot_ev || wr_addr_ev)
			begin
				stop_reg    <= 1'b1;
				xfer_active <= 1'b0;
			end
		end
	end

	// ****************************************
	// Interface checks and selective reset
	// ****************************************
	logic addr_par_bad, mux_poll_bad, sel_mis, ifc_set;
	logic [3:0] sr_cnt;
	assign addr_par_bad = if_ev && !(^ifb_q2);
	assign mux_poll_bad = addr_par_bad && cu_q2 && mux_q2;
	assign sel_mis      = sel_ev && (ifb_q2[7:0] != sent_q2);
	assign ifc_set      = (addr_par_bad && !mux_poll_bad) || sel_mis || tm_ev;

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			sr_cnt    <= 4'h0;
			sel_reset <= 1'b0;
		end
		else if (ifc_set || mux_poll_bad)
		begin
			sr_cnt    <= SEL_RST_CYC_W;
			sel_reset <= 1'b1;
		end
		else if (sr_cnt != 4'h0)
		begin
			sr_cnt    <= sr_cnt - 4'h1;
			sel_reset <= (sr_cnt != 4'h1);
		end
	end

	// ****************************************
	// Sticky status flags; a set beats a clear
	// ****************************************
	logic [ST_W-1:0] set_vec;
	always_comb
	begin
		set_vec          = '0;
		set_vec[ST_PROG] = prog_ccw || instr_invalid || bad_addr || wr_addr_ev;
		set_vec[ST_PROT] = (ccw_valid && ccw_prot_exc) || wr_prot_ev || bad_prot;
		set_vec[ST_DATA] = in_bus_par_err || (in_wr_done && in_wr_par) ||
			(send && bad_par);
		set_vec[ST_IFC]  = ifc_set;
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			status <= ST_RESET;
		else
			status <= (status_clear ? ST_RESET : status) | set_vec;
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			chain_allow <= 1'b0;
		else if (xfer_start)
			chain_allow <= ccw_chain;
		else if (set_vec[ST_DATA] || set_vec[ST_PROG])
			chain_allow <= 1'b0;
	end
endmodule
`default_nettype wire

// File: iocec_top_properties.sv
// Port assertions for the I/O channel error check block
`timescale 1ns/1ps
`default_nettype none
module iocec_props (
	input wire logic	sys_clk,	// Clock
	input wire logic	rst,	// Reset
	input wire logic	ccw_valid,	// Word strobe
	input wire logic [63:0]	ccw_word,	// Command word
	input wire logic	ccw_first,	// First of chain
	input wire logic	ccw_via_tic,	// Via transfer
	input wire logic	instr_invalid,	// Bad instruction
	input wire logic	in_wr_done,	// Input write
	input wire logic	in_wr_prot,	// Write protection
	input wire logic	in_bus_par_err,	// Bus parity
	input wire logic	status_clear,	// Clear
	input wire logic [7:0]	status,	// Flags
	input wire logic	chain_allow,	// Chaining
	input wire logic [7:0]	bus_out,	// Out byte
	input wire logic	bus_out_valid,	// Out valid
	input wire logic	bus_out_take,	// Out take
	input wire logic	sel_reset	// Selective reset
);
	// **********
	// Checks
	// **********
	logic [3:0] lo4;
	assign lo4 = ccw_word[59:56];
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	property p_code; ccw_valid && lo4 == 4'h0 |=> status[0]; endproperty
	a_code: assert property (p_code) else $error("bad code missed");
	property p_count; ccw_valid && ccw_word[15:0] == 16'h0 && lo4 != 4'h8 |=> status[0]; endproperty
	a_count: assert property (p_count) else $error("zero count missed");
	property p_tic; ccw_valid && lo4 == 4'h8 && (ccw_first || ccw_via_tic) |=> status[0]; endproperty
	a_tic: assert property (p_tic) else $error("transfer word missed");
	property p_pci; ccw_valid && ccw_first && ccw_word[29] |=> status[0]; endproperty
	a_pci: assert property (p_pci) else $error("first word flag missed");
	property p_rsv; ccw_valid && ccw_word[26:24] != 3'h0 |=> status[0]; endproperty
	a_rsv: assert property (p_rsv) else $error("reserved bits missed");
	property p_instr; instr_invalid |=> status[0]; endproperty
	a_instr: assert property (p_instr) else $error("bad instruction missed");
	property p_prot; in_wr_done && in_wr_prot |=> status[1]; endproperty
	a_prot: assert property (p_prot) else $error("protection missed");
	property p_data; in_bus_par_err |-> ##[1:2] (status[2] && !chain_allow); endproperty
	a_data: assert property (p_data) else $error("data check missed");
	property p_keep; !status_clear |=> (status & $past(status)) == $past(status); endproperty
	a_keep: assert property (p_keep) else $error("flag lost");
	property p_hold; bus_out_valid && !bus_out_take |=> bus_out_valid && $stable(bus_out); endproperty
	a_hold: assert property (p_hold) else $error("output byte dropped");
	property p_srst; $rose(sel_reset) |-> sel_reset[*5] ##1 !sel_reset; endproperty
	a_srst: assert property (p_srst) else $error("reset length wrong");
	c_srst: cover property ($rose(sel_reset));
	c_take: cover property (bus_out_valid && bus_out_take);
	c_data: cover property (in_bus_par_err ##[1:2] status[2]);
endmodule
bind iocec_top iocec_props u_props (.sys_clk, .rst, .ccw_valid, .ccw_word, .ccw_first,
	.ccw_via_tic, .instr_invalid, .in_wr_done, .in_wr_prot, .in_bus_par_err, .status_clear,
	.status, .chain_allow, .bus_out, .bus_out_valid, .bus_out_take, .sel_reset);
`default_nettype wire

// File: iocec_unit_model.sv
// Control unit model taking output bytes
`timescale 1ns/1ps
`default_nettype none
module iocec_unit_model (
	input wire logic	sys_clk,	// Clock
	input wire logic	rst,	// Reset
	input wire logic [7:0]	bus_out,	// Byte in
	input wire logic	bus_out_par,	// Parity in
	input wire logic	bus_out_valid,	// Byte shown
	input wire logic	slow,	// Stall
	output logic	bus_out_take,	// Take
	output logic [7:0]	got_b,	// Last byte
	output logic [7:0]	got_n,	// Bytes taken
	output logic [7:0]	par_errs	// Even bytes
);
	// Take every other cycle at most, so the channel sees gaps
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			bus_out_take <= 1'h0;
			got_b <= 8'h00;
			got_n <= 8'h00;
			par_errs <= 8'h00;
		end
		else
		begin
			bus_out_take <= bus_out_valid && !bus_out_take && !slow;
			if (bus_out_take && bus_out_valid)
			begin
				got_b <= bus_out;
				got_n <= got_n + 8'h01;
				if (!(^{bus_out, bus_out_par}))
					par_errs <= par_errs + 8'h01;
			end
		end
	end
endmodule
`default_nettype wire

// File: tb_io_channel_error_check.sv
// Testbench for the I/O channel error check block
`timescale 1ns/1ps
`default_nettype none
module tb_io_channel_error_check;
	logic sys_clk, rst, ccw_valid, ccw_first, ccw_via_tic, ccw_addr_exc, ccw_prot_exc;
	logic ccw_chain, instr_invalid, in_wr_done, in_wr_prot, in_wr_addr, in_wr_par;
	logic in_bus_par_err, out_byte_valid, out_byte_ready, out_byte_prot, out_byte_addr;
	logic out_byte_par, bus_out_par, bus_out_valid, bus_out_take, if_byte_stb;
	logic if_is_cu_addr, if_is_mux, sel_check, if_timing_err, xfer_start, unit_end;
	logic status_clear, chain_allow, xfer_active, sel_reset, slow;
	logic [63:0] ccw_word;
	logic [7:0] out_byte, bus_out, sel_sent_addr, status, got_b, got_n, par_errs;
	logic [8:0] if_byte;
	logic [15:0] xfer_count;
	int bad_count = 0;
	int compares = 0;
	iocec_top dut_u (.sys_clk, .rst, .ccw_valid, .ccw_word, .ccw_first, .ccw_via_tic,
		.ccw_addr_exc, .ccw_prot_exc, .ccw_chain, .instr_invalid, .in_wr_done, .in_wr_prot,
		.in_wr_addr, .in_wr_par, .in_bus_par_err, .out_byte_valid, .out_byte_ready, .out_byte,
		.out_byte_prot, .out_byte_addr, .out_byte_par, .bus_out, .bus_out_par, .bus_out_valid,
		.bus_out_take, .if_byte_stb, .if_byte, .if_is_cu_addr, .if_is_mux, .sel_check,
		.sel_sent_addr, .if_timing_err, .xfer_start, .xfer_count, .unit_end, .status_clear,
		.status, .chain_allow, .xfer_active, .sel_reset);
	iocec_unit_model unit_u (.sys_clk, .rst, .bus_out, .bus_out_par, .bus_out_valid, .slow,
		.bus_out_take, .got_b, .got_n, .par_errs);
	// **********
	// Helpers
	// **********
	task automatic chk(string n, logic [15:0] s, logic [15:0] e);
		compares++;
		if (s !== e)
		begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic cyc(int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task automatic clr;
		cyc(1);
		status_clear <= 1'h1;
		cyc(1);
		status_clear <= 1'h0;
	endtask
	task automatic go(logic [15:0] n);
		cyc(1);
		xfer_count <= n;
		xfer_start <= 1'h1;
		cyc(1);
		xfer_start <= 1'h0;
	endtask
	// Leaves valid up; caller drops it after the last byte
	task automatic push(logic [7:0] b, logic p, logic a, logic q);
		out_byte <= b;
		out_byte_prot <= p;
		out_byte_addr <= a;
		out_byte_par <= q;
		out_byte_valid <= 1'h1;
		do @(negedge sys_clk); while (out_byte_ready !== 1'h1);
		cyc(1);
	endtask
	// **********
	// Scenarios
	// **********
	task automatic channel_command_word(logic [63:0] w, logic f, logic t, logic p, logic [7:0] e);
		cyc(1);
		ccw_word <= w;
		ccw_first <= f;
		ccw_via_tic <= t;
		ccw_prot_exc <= p;
		ccw_valid <= 1'h1;
		cyc(1);
		ccw_valid <= 1'h0;
		cyc(1);
		#1 chk("word status", status, e);
		clr;
	endtask
	task automatic sticky;
		cyc(1);
		instr_invalid <= 1'h1;
		status_clear <= 1'h1;
		cyc(1);
		instr_invalid <= 1'h0;
		status_clear <= 1'h0;
		cyc(5);
		#1 chk("set over clear", status, 8'h01);
		cyc(1);
		in_wr_done <= 1'h1;
		in_wr_prot <= 1'h1;
		cyc(1);
		in_wr_done <= 1'h0;
		in_wr_prot <= 1'h0;
		cyc(2);
		#1 chk("both flags", status, 8'h03);
		clr;
		#1 chk("cleared", status, 8'h00);
	endtask
	task automatic data_check;
		ccw_chain <= 1'h1;
		go(16'h0003);
		slow <= 1'h1;
		cyc(1);
		chk("chain on", chain_allow, 1'h1);
		in_bus_par_err <= 1'h1;
		cyc(1);
		in_bus_par_err <= 1'h0;
		push(8'hA1, 1'h0, 1'h0, 1'h0);
		push(8'hA2, 1'h0, 1'h0, 1'h1);
		push(8'hA3, 1'h0, 1'h0, 1'h0);
		out_byte_valid <= 1'h0;
		cyc(4);
		#1 chk("stalled", got_n, 8'h00);
		chk("running", xfer_active, 1'h1);
		chk("chaining", chain_allow, 1'h0);
		chk("data flag", status, 8'h04);
		cyc(1);
		slow <= 1'h0;
		for (int i = 0; i < 40 && got_n != 8'h03; i++) cyc(1);
		#1 chk("bytes out", got_n, 8'h03);
		chk("last byte", got_b, 8'hA3);
		chk("even parity", par_errs, 8'h01);
		cyc(3);
		#1 chk("count end", xfer_active, 1'h0);
		clr;
	endtask
	task automatic bad_out(logic p, logic a, logic [7:0] e);
		logic [7:0] n0;
		n0 = got_n;
		go(16'h0004);
		push(8'h5A, 1'h0, 1'h0, 1'h0);
		push(8'hC3, p, a, 1'h0);
		out_byte_valid <= 1'h0;
		cyc(10);
		#1 chk("sent", got_n - n0, 8'h01);
		chk("fault flag", status, e);
		chk("stopped", xfer_active, 1'h0);
		clr;
	endtask
	task automatic ifc(logic [2:0] k, logic [8:0] b, logic cu, logic mx, logic [7:0] e, logic r);
		logic seen;
		seen = 1'h0;
		cyc(1);
		if_byte <= b;
		if_is_cu_addr <= cu;
		if_is_mux <= mx;
		sel_sent_addr <= 8'h05;
		cyc(2);
		{if_timing_err, sel_check, if_byte_stb} <= k;
		cyc(2);
		{if_timing_err, sel_check, if_byte_stb} <= 3'h0;
		repeat (12)
		begin
			cyc(1);
			#1 seen |= sel_reset;
		end
		chk("iface flag", status, e);
		chk("sel reset", seen, r);
		clr;
	endtask
	task automatic final_report;
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial
	begin
		sys_clk = 1'h0;
		forever #25 sys_clk = ~sys_clk;
	end
	initial
	begin
		cyc(5000);
		bad_count++;
		final_report;
	end
	initial
	begin
		rst = 1'h1;
		{ccw_valid, ccw_first, ccw_via_tic, ccw_addr_exc, ccw_prot_exc, ccw_chain, instr_invalid,
			in_wr_done, in_wr_prot, in_wr_addr, in_wr_par, in_bus_par_err, out_byte_valid,
			out_byte_prot, out_byte_addr, out_byte_par, if_byte_stb, if_is_cu_addr, if_is_mux,
			sel_check, if_timing_err, xfer_start, unit_end, status_clear, slow} = '0;
		{ccw_word, out_byte, sel_sent_addr, if_byte, xfer_count} = '0;
		cyc(3);
		rst <= 1'h0;
		channel_command_word(64'h0100000000000004, 1'h0, 1'h0, 1'h0, 8'h00);
		channel_command_word(64'h0000000000000004, 1'h0, 1'h0, 1'h0, 8'h01);
		channel_command_word(64'h0100000000000000, 1'h0, 1'h0, 1'h0, 8'h01);
		channel_command_word(64'h0800000000000000, 1'h0, 1'h0, 1'h0, 8'h00);
		channel_command_word(64'h0800000000000004, 1'h0, 1'h1, 1'h0, 8'h01);
		channel_command_word(64'h0800000000000004, 1'h0, 1'h0, 1'h0, 8'h00);
		channel_command_word(64'h0800000000000004, 1'h1, 1'h0, 1'h0, 8'h01);
		channel_command_word(64'h0100000020000004, 1'h1, 1'h0, 1'h0, 8'h01);
		channel_command_word(64'h0100000020000004, 1'h0, 1'h0, 1'h0, 8'h00);
		channel_command_word(64'h0100000001000004, 1'h0, 1'h0, 1'h0, 8'h01);
		channel_command_word(64'h0100000004000004, 1'h0, 1'h0, 1'h0, 8'h01);
		channel_command_word(64'h0100000000000004, 1'h0, 1'h0, 1'h1, 8'h02);
		sticky;
		data_check;
		bad_out(1'h1, 1'h0, 8'h02);
		bad_out(1'h0, 1'h1, 8'h01);
		ifc(3'h1, 9'h001, 1'h0, 1'h0, 8'h00, 1'h0);
		ifc(3'h1, 9'h003, 1'h0, 1'h0, 8'h08, 1'h1);
		ifc(3'h1, 9'h003, 1'h1, 1'h1, 8'h00, 1'h1);
		ifc(3'h1, 9'h003, 1'h1, 1'h0, 8'h08, 1'h1);
		ifc(3'h2, 9'h105, 1'h0, 1'h0, 8'h00, 1'h0);
		ifc(3'h2, 9'h007, 1'h0, 1'h0, 8'h08, 1'h1);
		ifc(3'h4, 9'h001, 1'h0, 1'h0, 8'h08, 1'h1);
		final_report;
	end
endmodule
`default_nettype wire
